// ---- include/aes_round_pkg.sv ----
package aes_round_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSTR = 8'h04;
	localparam logic [7:0] OFF_VCFG = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_STATE = 8'h20;
	localparam logic [7:0] OFF_KEY = 8'h30;
	localparam logic [7:0] OFF_RESULT = 8'h40;
	localparam logic [7:0] OFF_LAST = 8'h4c;
	localparam int CTRL_GO = 0;
	localparam int VL_LSB = 0;
	localparam int VST_LSB = 8;
	localparam int SEW_LSB = 16;
	localparam int REGISTER_GROUP_MULTIPLIER_LSB = 19;
	localparam int EGS_SHIFT = 2;
	localparam logic [2:0] SEW_32 = 3'h2;
	localparam int ELEMENT_GROUP_WIDTH = 128;
	localparam int STAT_BUSY = 0;
	localparam int STAT_END = 1;
	localparam int STAT_ILL = 2;
	localparam int STAT_CUR_LSB = 8;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ILL = 1;
	localparam int F6_LSB = 26;
	localparam int VM_BIT = 25;
	localparam int VS2_LSB = 20;
	localparam int VS1_LSB = 15;
	localparam int F3_LSB = 12;
	localparam int VD_LSB = 7;
	localparam logic [5:0] FUNCT6_VV = 6'h28;
	localparam logic [5:0] FUNCT6_VS = 6'h29;
	localparam logic [4:0] VS1_DM = 5'h00;
	localparam logic [4:0] VS1_DF = 5'h01;
	localparam logic [4:0] VS1_EM = 5'h02;
	localparam logic [4:0] VS1_EF = 5'h03;
	localparam logic [7:0] GF_POLY = 8'h1b;
	localparam logic [7:0] AFF_FWD = 8'h63;
	localparam logic [7:0] AFF_INV = 8'h05;
	localparam logic [31:0] MIX_FWD = 32'h01010302;
	localparam logic [31:0] MIX_INV = 32'h090d0b0e;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} state_type;
	typedef enum logic [1:0] {
		OP_DF = 2'b00,
		OP_DM = 2'b01,
		OP_EF = 2'b10,
		OP_EM = 2'b11
	} round_op_type;
endpackage

// ---- logic/vector_aes_round_unit.sv ----
// Function
// RL1: decode final decrypt, vs1 code 00001
// RL2: decode middle decrypt, vs1 code 00000
// RL3: decode final encrypt, vs1 code 00011
// RL4: decode middle encrypt, vs1 code 00010
// RL5: element width not 32 is reserved
// RL6: scalar form, destination overlapping key reserved
// RL7: group too narrow for 128 bits: illegal
// RL8: walk groups start/4 to count/4-1
// RL9: key per group, or group zero
// RL10: final decrypt: inv shift, inv sub, xor
// RL11: middle decrypt: inv shift, sub, xor, mix; the code applies inv sub here
// RL12: final encrypt: sub, shift, xor key
// RL13: latency fixed, independent of data
// RL14: middle encrypt: sub, shift, mix, xor
// RL15: reserved encodings trap, destination unchanged
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module vector_aes_round_unit #(
	parameter int VECTOR_REGISTER_BITS_BITS = 128,
	parameter int LATENCY = 2,
	parameter logic [6:0] MAJOR_OPCODE = 7'h77,
	parameter logic [2:0] MULT_CLASS = 3'h2
)(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [aes_round_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [aes_round_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic irq_o
);
	import aes_round_pkg::*;

	if (LATENCY < 1 || LATENCY > 255 || VECTOR_REGISTER_BITS_BITS < 32)
	begin : bad_param
		$error("unsupported LATENCY or VECTOR_REGISTER_BITS_BITS");
	end

	function automatic logic [7:0] xt(input logic [7:0] a);
		return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ x;
			x = xt(x);
		end
		return p;
	endfunction

	// a^254 by square-and-multiply; maps zero to zero as the s-box needs
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] s;
		r = 8'h01;
		s = a;
		for (int i = 1; i < 8; i++)
		begin
			s = gm(s, s);
			r = gm(r, s);
		end
		return r;
	endfunction

	function automatic logic [7:0] rl(input logic [7:0] a, input int n);
		logic [15:0] d;
		d = {a, a} << n;
		return d[15:8];
	endfunction

	// computed s-box, no table: no data-dependent lookup timing
	function automatic logic [127:0] sub(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		logic [7:0] v;
		o = '0;
		for (int j = 0; j < 16; j++)
		begin
			if (inv)
				o[8*j +: 8] = ginv(rl(s[8*j +: 8], 1) ^ rl(s[8*j +: 8], 3)
					^ rl(s[8*j +: 8], 6) ^ AFF_INV);
			else
			begin
				v = ginv(s[8*j +: 8]);
				o[8*j +: 8] = v ^ rl(v, 1) ^ rl(v, 2) ^ rl(v, 3) ^ rl(v, 4)
					^ AFF_FWD;
			end
		end
		return o;
	endfunction

	function automatic logic [127:0] shr(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		int k;
		o = '0;
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++)
			begin
				k = inv ? (c + 4 - r) % 4 : (c + r) % 4;
				o[8*(r+4*c) +: 8] = s[8*(r+4*k) +: 8];
			end
		return o;
	endfunction

	function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		logic [31:0] m;
		logic [7:0] b;
		o = '0;
		m = inv ? MIX_INV : MIX_FWD;
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++)
			begin
				b = 8'h00;
				for (int t = 0; t < 4; t++)
					b = b ^ gm(s[8*(4*c+(r+t)%4) +: 8], m[8*t +: 8]);
				o[8*(4*c+r) +: 8] = b;
			end
		return o;
	endfunction

	function automatic logic [127:0] aes_round(input round_op_type op,
		input logic [127:0] s, input logic [127:0] k);
		case (op)
			OP_DF: return sub(shr(s, 1'b1), 1'b1) ^ k; // [RL10]
			OP_DM: return mix(sub(shr(s, 1'b1), 1'b1) ^ k, 1'b1); // [RL11]
			OP_EF: return shr(sub(s, 1'b0), 1'b0) ^ k; // [RL12]
			OP_EM: return mix(shr(sub(s, 1'b0), 1'b0), 1'b0) ^ k; // [RL14]
			default: return s;
		endcase
	endfunction

	function automatic logic [31:0] wm(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i +: 8] = d[8*i +: 8];
		return o;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a[1:0] == 2'b00 && (a <= OFF_IRQ_MASK
			|| (a >= OFF_STATE && a <= OFF_LAST));
	endfunction

	state_type st;
	round_op_type run_op;
	round_op_type dec_op;
	logic aw_have, w_have, wr_en, go, form_ok, dec_ok, scalar, overlap;
	logic width_ok, illegal, first_grp, last_ill, run_scalar;
	logic done_pulse, ill_pulse, finish;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data, instr, vcfg, eff_bits, rd_val, stat, next_vcfg;
	logic [3:0] w_strb;
	logic [31:0] state_w [4];
	logic [31:0] key_w [4];
	logic [31:0] result_w [4];
	logic [127:0] key_hold, op_state, op_key, round_out, state_vec, key_vec;
	logic [1:0] irq_stat, irq_mask, irq_clr;
	logic [5:0] cursor, n_regs, eg_len, eg_start, vs2, vd;
	logic [4:0] vs1;
	logic [2:0] register_group_multiplier;
	logic [7:0] cnt, ast_cnt;

	assign s_axi_awready_o = !aw_have;
	assign s_axi_wready_o = !w_have;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_en = aw_have && w_have && !s_axi_bvalid_o;
	assign go = wr_en && aw_addr == OFF_CTRL && w_strb[0] && w_data[CTRL_GO];

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end
		else
		begin
			if (s_axi_awvalid_i && !aw_have)
			begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			else if (wr_en)
				aw_have <= 1'b0;
			if (s_axi_wvalid_i && !w_have)
			begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			else if (wr_en)
				w_have <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= RESP_OKAY;
			s_axi_rdata_o <= '0;
		end
		else
		begin
			if (wr_en)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (s_axi_arvalid_i && !s_axi_rvalid_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_val;
				s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	// software-visible settings; writes to status and result are ignored
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			instr <= '0;
			vcfg <= '0;
			irq_mask <= '0;
			for (int i = 0; i < 4; i++)
			begin
				state_w[i] <= '0;
				key_w[i] <= '0;
			end
		end
		else if (wr_en)
		begin
			if (aw_addr == OFF_INSTR)
				instr <= wm(instr, w_data, w_strb);
			if (aw_addr == OFF_VCFG)
				vcfg <= next_vcfg;
			if (aw_addr == OFF_IRQ_MASK && w_strb[0])
				irq_mask <= w_data[1:0];
			if (aw_addr[7:4] == OFF_STATE[7:4])
				state_w[aw_addr[3:2]] <= wm(state_w[aw_addr[3:2]], w_data, w_strb);
			if (aw_addr[7:4] == OFF_KEY[7:4])
				key_w[aw_addr[3:2]] <= wm(key_w[aw_addr[3:2]], w_data, w_strb);
		end
	end

	assign next_vcfg = wm(vcfg, w_data, w_strb);
	assign state_vec = {state_w[3], state_w[2], state_w[1], state_w[0]};
	assign key_vec = {key_w[3], key_w[2], key_w[1], key_w[0]};
	assign vs1 = instr[VS1_LSB +: 5];
	assign vs2 = {1'b0, instr[VS2_LSB +: 5]};
	assign vd = {1'b0, instr[VD_LSB +: 5]};
	assign register_group_multiplier = vcfg[REGISTER_GROUP_MULTIPLIER_LSB +: 3];
	assign eg_len = vcfg[VL_LSB+EGS_SHIFT +: 6];
	assign eg_start = vcfg[VST_LSB+EGS_SHIFT +: 6];
	assign scalar = instr[F6_LSB +: 6] == FUNCT6_VS;
	assign form_ok = instr[VM_BIT] && instr[F3_LSB +: 3] == MULT_CLASS
		&& instr[6:0] == MAJOR_OPCODE
		&& (instr[F6_LSB +: 6] == FUNCT6_VV || scalar);
	assign n_regs = register_group_multiplier[2] ? 6'h01 : 6'(1 << register_group_multiplier);
	assign overlap = scalar && vs2 >= vd && vs2 < vd + n_regs; // [RL6]
	assign eff_bits = register_group_multiplier[2] ? 32'(VECTOR_REGISTER_BITS_BITS >> (4'h8 - {1'b0, register_group_multiplier}))
		: 32'(VECTOR_REGISTER_BITS_BITS << register_group_multiplier);
	assign width_ok = eff_bits >= ELEMENT_GROUP_WIDTH; // [RL7]
	assign illegal = !form_ok || !dec_ok || vcfg[SEW_LSB +: 3] != SEW_32 // [RL5]
		|| overlap || !width_ok || cursor >= eg_len; // [RL15]

	always_comb
	begin
		dec_ok = 1'b1;
		case (vs1)
			VS1_DF: dec_op = OP_DF; // [RL1]
			VS1_DM: dec_op = OP_DM; // [RL2]
			VS1_EF: dec_op = OP_EF; // [RL3]
			VS1_EM: dec_op = OP_EM; // [RL4]
			default:
			begin
				dec_op = OP_DF;
				dec_ok = 1'b0;
			end
		endcase
	end

	assign finish = st == ST_RUN && cnt == 8'h00;
	assign round_out = aes_round(run_op, op_state, op_key);

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= ST_IDLE;
			cnt <= '0;
			run_op <= OP_DF;
			run_scalar <= 1'b0;
			op_state <= '0;
			op_key <= '0;
			done_pulse <= 1'b0;
			ill_pulse <= 1'b0;
		end
		else
		begin
			done_pulse <= finish;
			ill_pulse <= st == ST_IDLE && go && illegal;
			case (st)
				ST_IDLE:
					if (go && !illegal)
					begin
						st <= ST_RUN;
						cnt <= 8'(LATENCY - 1); // [RL13]
						run_op <= dec_op;
						run_scalar <= scalar;
						op_state <= state_vec;
						op_key <= (scalar && !first_grp) ? key_hold : key_vec; // [RL9]
					end
				ST_RUN:
					if (cnt == 8'h00)
						st <= ST_IDLE;
					else
						cnt <= cnt - 8'h01;
				default: st <= ST_IDLE;
			endcase
		end
	end

	// a group walk restarts whenever the vector settings are rewritten
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cursor <= '0;
			first_grp <= 1'b1;
			key_hold <= '0;
			last_ill <= 1'b0;
		end
		else
		begin
			if (st == ST_IDLE && go && !illegal && first_grp)
				key_hold <= key_vec; // [RL9]
			if (wr_en && aw_addr == OFF_VCFG)
			begin
				cursor <= next_vcfg[VST_LSB+EGS_SHIFT +: 6]; // [RL8]
				first_grp <= 1'b1;
			end
			else if (finish)
			begin
				cursor <= cursor + 6'h01; // [RL8]
				first_grp <= 1'b0;
			end
			if (st == ST_IDLE && go && illegal)
				last_ill <= 1'b1;
			else if (finish)
				last_ill <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			for (int i = 0; i < 4; i++)
				result_w[i] <= '0;
		else if (finish)
			for (int i = 0; i < 4; i++)
				result_w[i] <= round_out[32*i +: 32]; // [RL8]
	end

	assign irq_clr = (wr_en && aw_addr == OFF_IRQ_STAT && w_strb[0])
		? w_data[1:0] : 2'b00;

	// set beats clear so an event in the clearing cycle survives
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_stat <= '0;
		else
		begin
			irq_stat[IRQ_DONE] <= (irq_stat[IRQ_DONE] & ~irq_clr[IRQ_DONE])
				| done_pulse;
			irq_stat[IRQ_ILL] <= (irq_stat[IRQ_ILL] & ~irq_clr[IRQ_ILL])
				| ill_pulse; // [RL15]
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	always_comb
	begin
		stat = '0;
		stat[STAT_BUSY] = st == ST_RUN;
		stat[STAT_END] = cursor >= eg_len;
		stat[STAT_ILL] = last_ill;
		stat[STAT_CUR_LSB +: 6] = cursor;
		rd_val = '0;
		case (s_axi_araddr_i)
			OFF_INSTR: rd_val = instr;
			OFF_VCFG: rd_val = vcfg;
			OFF_STATUS: rd_val = stat;
			OFF_IRQ_STAT: rd_val = {30'h0, irq_stat};
			OFF_IRQ_MASK: rd_val = {30'h0, irq_mask};
			default:
				if (s_axi_araddr_i[1:0] == 2'b00)
				begin
					if (s_axi_araddr_i[7:4] == OFF_STATE[7:4])
						rd_val = state_w[s_axi_araddr_i[3:2]];
					else if (s_axi_araddr_i[7:4] == OFF_KEY[7:4])
						rd_val = key_w[s_axi_araddr_i[3:2]];
					else if (s_axi_araddr_i[7:4] == OFF_RESULT[7:4])
						rd_val = result_w[s_axi_araddr_i[3:2]];
				end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ast_cnt <= '0;
		else
			ast_cnt <= (st == ST_RUN) ? ast_cnt + 8'h01 : 8'h00;
	end

	AST_FIXED_LAT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL13]
		done_pulse |-> ast_cnt == 8'(LATENCY))
		else $error("round latency differs from LATENCY");
	AST_DF_DECODE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL1]
		(st == ST_IDLE && go && !illegal && vs1 == VS1_DF)
		|=> st == ST_RUN && run_op == OP_DF)
		else $error("final decrypt not decoded");
	AST_EM_DECODE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL4]
		(st == ST_IDLE && go && !illegal && vs1 == VS1_EM)
		|=> st == ST_RUN && run_op == OP_EM)
		else $error("middle encrypt not decoded");
	AST_SEW_TRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL5]
		(st == ST_IDLE && go && vcfg[SEW_LSB +: 3] != SEW_32) |=> ill_pulse)
		else $error("bad element width accepted");
	AST_OVERLAP_TRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL6]
		(st == ST_IDLE && go && overlap) |=> ill_pulse && st == ST_IDLE)
		else $error("overlapping scalar form accepted");
	AST_WIDTH_TRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL7]
		(st == ST_IDLE && go && !width_ok) |=> ill_pulse)
		else $error("narrow group accepted");
	AST_CURSOR_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL8]
		(done_pulse && !$past(wr_en)) |-> cursor == $past(cursor) + 6'h01)
		else $error("group index did not advance");
	AST_SCALAR_KEY: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL9]
		(st == ST_RUN && run_scalar) |-> op_key == key_hold)
		else $error("scalar form used wrong key");
	AST_TRAP_NO_WRITE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RL15]
		(st == ST_IDLE && go && illegal)
		|=> ##1 $stable(result_w[0]) && irq_stat[IRQ_ILL])
		else $error("reserved encoding changed result");
endmodule // vector_aes_round_unit

// ---- tb/vector_pipe_model.sv ----
`timescale 1ns/1ps
module vector_pipe_model
(
	input wire logic clk_i,
	output logic [aes_round_pkg::ADDR_W-1:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [aes_round_pkg::ADDR_W-1:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	import aes_round_pkg::*;
	initial
	begin
		awaddr_o = '0;
		awvalid_o = 1'b0;
		wdata_o = '0;
		wvalid_o = 1'b0;
		bready_o = 1'b0;
		araddr_o = '0;
		arvalid_o = 1'b0;
		rready_o = 1'b0;
	end
	// handshakes are judged at the rising edge, on values before it settles
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic fin;
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		fin = 1'b0;
		r = 2'h0;
		while (!fin)
		begin
			@(posedge clk_i);
			if (awvalid_o && awready_i)
				awvalid_o <= 1'b0;
			if (wvalid_o && wready_i)
				wvalid_o <= 1'b0;
			if (bvalid_i && bready_o)
			begin
				fin = 1'b1;
				r = bresp_i;
			end
		end
		bready_o <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic fin;
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		fin = 1'b0;
		d = '0;
		r = 2'h0;
		while (!fin)
		begin
			@(posedge clk_i);
			if (arvalid_o && arready_i)
				arvalid_o <= 1'b0;
			if (rvalid_i && rready_o)
			begin
				fin = 1'b1;
				d = rdata_i;
				r = rresp_i;
			end
		end
		rready_o <= 1'b0;
	endtask
endmodule // vector_pipe_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import aes_round_pkg::*;
	localparam int LAT = 3;
	logic ref_clk, rst, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] sb [256];
	logic [7:0] isb [256];
	logic [127:0] exp_res, mkey;
	logic [31:0] seed, d;
	logic [1:0] r;
	logic pb, pi, first;
	int error_cnt, tests_run, cyc, lcnt, lat, cur, cnt;
	vector_aes_round_unit #(.LATENCY(LAT)) dut_u (.ref_clk_i(ref_clk),
		.rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .irq_o(irq));
	vector_pipe_model pm_u (.clk_i(ref_clk), .awaddr_o(awaddr),
		.awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
		.wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
		.bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// cycles from the last write answer to the interrupt rising
	always @(posedge ref_clk)
	begin
		pb <= bvalid;
		pi <= irq;
		cyc <= cyc + 1;
		lcnt <= (bvalid && !pb) ? 1 : lcnt + 1;
		if (irq && !pi)
			lat <= lcnt;
		if (cyc == 30000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr_next();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction
	function automatic logic [7:0] gm(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ a;
			a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
		end
		return p;
	endfunction
	function automatic logic [127:0] mix(input logic [127:0] v,
		input logic [31:0] m);
		logic [127:0] o;
		o = '0;
		for (int c = 0; c < 4; c++)
			for (int w = 0; w < 4; w++)
				for (int i = 0; i < 4; i++)
					o[8*(4*c+w)+:8] ^= gm(v[8*(4*c+(w+i)%4)+:8], m[8*i+:8]);
		return o;
	endfunction
	function automatic logic [127:0] aes_ref(input logic [4:0] code,
		input logic [127:0] s, input logic [127:0] k);
		logic [127:0] b;
		for (int c = 0; c < 4; c++)
			for (int w = 0; w < 4; w++)
				if (code[1])
					b[8*(4*c+w)+:8] = sb[s[8*(4*((c+w)%4)+w)+:8]];
				else
					b[8*(4*((c+w)%4)+w)+:8] = isb[s[8*(4*c+w)+:8]];
		if (code == 5'h2)
			b = mix(b, 32'h01010302);
		b = b ^ k;
		if (code == 5'h0)
			b = mix(b, 32'h090d0b0e);
		return b;
	endfunction
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cfg(input int c, input int s, input logic [2:0] w,
		input logic [2:0] m);
		pm_u.wr(OFF_VCFG, {10'h0, m, w, 8'(s), 8'(c)}, r);
		cnt = c;
		cur = s / 4;
		first = 1'b1;
	endtask
	task automatic op(input logic [4:0] code, input logic sc,
		input logic [4:0] vd, input logic [4:0] ks, input logic ok);
		logic [127:0] st;
		logic [127:0] ky;
		st = {lfsr_next(), lfsr_next(), lfsr_next(), lfsr_next()};
		ky = {lfsr_next(), lfsr_next(), lfsr_next(), lfsr_next()};
		pm_u.wr(OFF_INSTR, {sc ? FUNCT6_VS : FUNCT6_VV, 1'b1, ks, code,
			3'h2, vd, 7'h77}, r);
		for (int i = 0; i < 4; i++)
		begin
			pm_u.wr(OFF_STATE + 8'(4*i), st[32*i+:32], r);
			pm_u.wr(OFF_KEY + 8'(4*i), ky[32*i+:32], r);
		end
		pm_u.wr(OFF_IRQ_STAT, 32'h3, r);
		pm_u.wr(OFF_CTRL, 32'h1, r);
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(negedge ref_clk);
		@(posedge ref_clk);
		#1;
		if (ok)
		begin
			// scalar key is captured once per walk, then reused
			if (!sc || first)
				mkey = ky;
			first = 1'b0;
			exp_res = aes_ref(code, st, mkey);
			cur++;
			chk("latency", 32'(LAT + 1), 32'(lat));
		end
		pm_u.rd(OFF_IRQ_STAT, d, r);
		chk("irq status", ok ? 32'h1 : 32'h2, d);
		pm_u.rd(OFF_STATUS, d, r);
		chk("status", {18'h0, 6'(cur), 5'h0, !ok, cur >= cnt / 4, 1'b0},
			d);
		for (int i = 0; i < 4; i++)
		begin
			pm_u.rd(OFF_RESULT + 8'(4*i), d, r);
			chk("result", exp_res[32*i+:32], d);
		end
	endtask
	initial
	begin
		rst = 1'b1;
		seed = 32'd91;
		exp_res = '0;
		mkey = '0;
		for (int x = 0; x < 256; x++)
		begin
			logic [7:0] inv, t, s;
			inv = 8'h01;
			repeat (254) inv = gm(inv, 8'(x));
			t = inv;
			s = inv;
			repeat (4)
			begin
				t = {t[6:0], t[7]};
				s = s ^ t;
			end
			sb[x] = s ^ 8'h63;
			isb[s ^ 8'h63] = 8'(x);
		end
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		pm_u.rd(OFF_STATUS, d, r);
		// empty walk: cursor already at the end
		chk("status after reset", 32'h2, d);
		chk("read resp", 32'(RESP_OKAY), 32'(r));
		pm_u.wr(OFF_IRQ_MASK, 32'h3, r);
		chk("write resp", 32'(RESP_OKAY), 32'(r));
		for (int k = 0; k < 8; k++)
		begin
			cfg(8, 0, 3'h2, 3'h0);
			op(5'(k % 4), k / 4, 5'h4, 5'h8, 1'b1);
		end
		cfg(4, 0, 3'h2, 3'h0);
		op(5'h1, 1'b0, 5'h4, 5'h4, 1'b1);
		cfg(12, 4, 3'h2, 3'h0);
		op(5'h2, 1'b1, 5'h4, 5'h8, 1'b1);
		op(5'h3, 1'b1, 5'h4, 5'h8, 1'b1);
		op(5'h1, 1'b0, 5'h4, 5'h8, 1'b0);
		cfg(8, 0, 3'h1, 3'h0);
		op(5'h1, 1'b0, 5'h4, 5'h8, 1'b0);
		cfg(8, 0, 3'h2, 3'h0);
		op(5'h0, 1'b1, 5'h4, 5'h4, 1'b0);
		op(5'h4, 1'b0, 5'h4, 5'h8, 1'b0);
		cfg(8, 0, 3'h2, 3'h2);
		op(5'h3, 1'b1, 5'h8, 5'h9, 1'b0);
		op(5'h3, 1'b1, 5'h8, 5'hc, 1'b1);
		cfg(8, 0, 3'h2, 3'h5);
		op(5'h3, 1'b0, 5'h4, 5'h8, 1'b0);
		pm_u.wr(OFF_IRQ_MASK, 32'h1, r);
		@(negedge ref_clk);
		chk("irq masked", 32'h0, 32'(irq));
		pm_u.wr(OFF_IRQ_MASK, 32'h3, r);
		@(negedge ref_clk);
		chk("irq unmasked", 32'h1, 32'(irq));
		pm_u.wr(OFF_IRQ_STAT, 32'h2, r);
		@(negedge ref_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		pm_u.rd(8'h18, d, r);
		chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped read data", 32'h0, d);
		pm_u.wr(8'h1c, 32'h5, r);
		chk("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
		pm_u.wr(OFF_RESULT, ~exp_res[31:0], r);
		pm_u.rd(OFF_RESULT, d, r);
		chk("read-only result", exp_res[31:0], d);
		report_and_stop();
	end
endmodule // testbench
